/* hdl/nvw_pkg.sv */
// Constants shared by the nonvolatile data memory write control block
`default_nettype none
package nvw_pkg;
  // ****************************************************************
  // Address map
  // ****************************************************************
  localparam int unsigned NVW_ADDR_W = 12;
  localparam logic [11:0] NVW_CTRL_ADDR = 12'hfce;
  localparam logic [7:0] NVW_ARRAY_BANK = 8'h04;
  localparam int unsigned NVW_DEPTH = 16;
  localparam int unsigned NVW_IDX_W = 4;
  // ****************************************************************
  // Control register layout and reset value
  // ****************************************************************
  localparam int unsigned NVW_BIT_READ_EN = 7;
  localparam int unsigned NVW_SEL_LSB = 4;
  localparam int unsigned NVW_SEL_MSB = 6;
  localparam int unsigned NVW_BIT_WRITE_EN = 3;
  localparam int unsigned NVW_BIT_BUSY = 2;
  localparam logic [7:0] NVW_CTRL_RESET = 8'h00;
  localparam logic [1:0] NVW_UNUSED_BITS = 2'h0;
  // ****************************************************************
  // Write timing: 18 x 2^13 system clocks at select code 000
  // ****************************************************************
  localparam int unsigned NVW_TIME_FACTOR = 18;
  localparam int unsigned NVW_TIME_MAX_EXP = 13;
  localparam int unsigned NVW_LONG_WRITE_CYCLES =
    NVW_TIME_FACTOR * (2 ** NVW_TIME_MAX_EXP);
  localparam int unsigned NVW_CNT_W = 18;
  localparam logic [17:0] NVW_CNT_ONE = 18'h00001;
  localparam logic [17:0] NVW_CNT_ZERO = 18'h00000;
  localparam logic [7:0] NVW_ERASED = 8'h00;
  // ****************************************************************
  // Sequencer states
  // ****************************************************************
  typedef enum logic [1:0] {
    NVW_IDLE = 2'b00,
    NVW_ERASE = 2'b01,
    NVW_PROGRAM = 2'b10
  } nvw_state_t;
endpackage : nvw_pkg
`default_nettype wire

/* hdl/nvw_timer.sv */
// Write duration timer of the nonvolatile data memory
`default_nettype none
module nvw_timer
  import nvw_pkg::*;
#(
  parameter int unsigned P_LONG_WRITE_CYCLES = NVW_LONG_WRITE_CYCLES
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // Sequencer side
  nvw_timer_if.tmr tif
);
  logic [NVW_CNT_W-1:0] count;
  logic [NVW_CNT_W-1:0] next_count;
  logic run;
  logic next_run;
  logic done;
  logic next_done;
  logic [NVW_CNT_W-1:0] span;

  // ****************************************************************
  // Count down from the selected duration
  // ****************************************************************
  always_comb begin
    span = NVW_CNT_W'(P_LONG_WRITE_CYCLES >> tif.sel);
    next_count = count;
    next_run = run;
    next_done = 1'b0;
    if (tif.abort) begin
      next_run = 1'b0;
    end else if (tif.load) begin
      next_count = span - NVW_CNT_ONE;
      next_run = 1'b1;
    end else if (run) begin
      if (count == NVW_CNT_ZERO) begin
        next_run = 1'b0;
        next_done = 1'b1;
      end else begin
        next_count = count - NVW_CNT_ONE;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      count <= NVW_CNT_ZERO;
      run <= 1'b0;
      done <= 1'b0;
    end else begin
      count <= next_count;
      run <= next_run;
      done <= next_done;
    end
  end

  assign tif.done = done;
endmodule : nvw_timer
`default_nettype wire

/* hdl/nvw_timer_if.sv */
// Link between the write sequencer and its duration timer
`default_nettype none
interface nvw_timer_if;
  logic load;
  logic abort;
  logic [2:0] sel;
  logic done;
  modport seq (output load, output abort, output sel, input done);
  modport tmr (input load, input abort, input sel, output done);
endinterface : nvw_timer_if
`default_nettype wire

/* hdl/nvw_top.sv */
// Nonvolatile data memory with its write control register and sequencer
`default_nettype none
module nvw_top
  import nvw_pkg::*;
#(
  parameter int unsigned P_LONG_WRITE_CYCLES = NVW_LONG_WRITE_CYCLES
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // CPU data memory access
  input wire logic [NVW_ADDR_W-1:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_byte,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  // CPU power modes
  input wire logic i_stop_mode,
  input wire logic i_halt_mode,
  // Status towards the interrupt controller
  output logic o_write_end_interrupt,
  output logic o_write_busy_flag
);
  // ****************************************************************
  // Declarations
  // ****************************************************************
  nvw_timer_if tif ();
  nvw_state_t state;
  nvw_state_t next_state;
  logic read_enable_flag;
  logic next_read_enable_flag;
  logic [2:0] write_time_select;
  logic [2:0] next_write_time_select;
  logic write_enable_bit;
  logic next_write_enable_bit;
  logic write_busy_flag;
  logic next_write_busy_flag;
  logic [NVW_IDX_W-1:0] tgt_idx;
  logic [NVW_IDX_W-1:0] next_tgt_idx;
  logic [7:0] tgt_data;
  logic [7:0] next_tgt_data;
  logic write_end;
  logic next_write_end;
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  logic rvalid;
  logic next_rvalid;
  logic mem_we;
  logic [7:0] mem_val;
  logic [7:0] mem [NVW_DEPTH];
  logic ctrl_wr;
  logic arr_wr;
  logic arr_rd;
  logic [7:0] ctrl_byte;
  logic halt_seen;

  // Byte access to one of the sixteen array cells
  function automatic logic is_array(input logic [NVW_ADDR_W-1:0] a,
                                    input logic byte_acc);
    is_array = byte_acc && (a[11:4] == {NVW_ARRAY_BANK[3:0], 4'h0});
  endfunction : is_array

  // ****************************************************************
  // Access decode
  // ****************************************************************
  assign ctrl_wr = i_wr && i_byte && (i_addr == NVW_CTRL_ADDR);
  assign arr_wr = i_wr && is_array(i_addr, i_byte);
  assign arr_rd = i_rd && is_array(i_addr, i_byte);
  // Halt leaves the sequencer running; the input only masks the read answer on o_rvalid
  assign halt_seen = i_halt_mode;
  assign ctrl_byte = {read_enable_flag, write_time_select,
                      write_enable_bit, write_busy_flag,
                      NVW_UNUSED_BITS};

  // ****************************************************************
  // Control register and write sequencer
  // ****************************************************************
  always_comb begin
    next_state = state;
    next_read_enable_flag = read_enable_flag;
    next_write_time_select = write_time_select;
    next_write_enable_bit = write_enable_bit;
    next_write_busy_flag = write_busy_flag;
    next_tgt_idx = tgt_idx;
    next_tgt_data = tgt_data;
    next_write_end = 1'b0;
    mem_we = 1'b0;
    mem_val = tgt_data;
    tif.load = 1'b0;
    tif.abort = 1'b0;
    tif.sel = write_time_select;
    if (ctrl_wr) begin
      next_read_enable_flag = i_wdata[NVW_BIT_READ_EN];
      next_write_time_select = i_wdata[NVW_SEL_MSB:NVW_SEL_LSB];
      next_write_enable_bit = i_wdata[NVW_BIT_WRITE_EN];
    end
    case (state)
      NVW_IDLE: begin
        // Writes while busy never reach this branch
        if (arr_wr && write_enable_bit && !read_enable_flag &&
            !write_busy_flag && !ctrl_wr && !i_stop_mode) begin
          next_tgt_idx = i_addr[NVW_IDX_W-1:0];
          next_tgt_data = i_wdata;
          next_write_busy_flag = 1'b1;
          tif.load = 1'b1;
          next_state = NVW_ERASE;
        end
      end
      NVW_ERASE, NVW_PROGRAM: begin
        if (i_stop_mode) begin
          tif.abort = 1'b1;
          next_write_busy_flag = 1'b0;
          next_state = NVW_IDLE;
        end else if (ctrl_wr && !i_wdata[NVW_BIT_WRITE_EN]) begin
          tif.abort = 1'b1;
          mem_we = 1'b1;
          mem_val = NVW_ERASED;
          next_write_busy_flag = 1'b0;
          next_state = NVW_IDLE;
        end else if (state == NVW_ERASE) begin
          mem_we = 1'b1;
          mem_val = NVW_ERASED;
          next_state = NVW_PROGRAM;
        end else if (tif.done) begin
          mem_we = 1'b1;
          mem_val = tgt_data;
          next_write_busy_flag = 1'b0;
          next_write_end = 1'b1;
          next_state = NVW_IDLE;
        end
      end
      default: begin
        next_write_busy_flag = 1'b0;
        next_state = NVW_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= NVW_IDLE;
      read_enable_flag <= NVW_CTRL_RESET[NVW_BIT_READ_EN];
      write_time_select <= NVW_CTRL_RESET[NVW_SEL_MSB:NVW_SEL_LSB];
      write_enable_bit <= NVW_CTRL_RESET[NVW_BIT_WRITE_EN];
      write_busy_flag <= NVW_CTRL_RESET[NVW_BIT_BUSY];
      tgt_idx <= '0;
      tgt_data <= NVW_ERASED;
      write_end <= 1'b0;
    end else begin
      state <= next_state;
      read_enable_flag <= next_read_enable_flag;
      write_time_select <= next_write_time_select;
      write_enable_bit <= next_write_enable_bit;
      write_busy_flag <= next_write_busy_flag;
      tgt_idx <= next_tgt_idx;
      tgt_data <= next_tgt_data;
      write_end <= next_write_end;
    end
  end

  // ****************************************************************
  // Nonvolatile cells: kept across reset
  // ****************************************************************
  always_ff @(posedge i_mclk) begin
    if (mem_we) begin
      mem[tgt_idx] <= mem_val;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  always_comb begin
    next_rvalid = i_rd;
    next_rdata = 8'h00;
    if (i_rd && (i_addr == NVW_CTRL_ADDR)) begin
      next_rdata = ctrl_byte;
    end else if (arr_rd && read_enable_flag && !write_enable_bit &&
                 !write_busy_flag) begin
      next_rdata = mem[i_addr[NVW_IDX_W-1:0]];
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      rdata <= next_rdata;
      rvalid <= next_rvalid && !halt_seen;
    end
  end

  // ****************************************************************
  // Duration timer
  // ****************************************************************
  nvw_timer #(
    .P_LONG_WRITE_CYCLES(P_LONG_WRITE_CYCLES)
  ) u_timer (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .tif(tif)
  );

  assign o_rdata = rdata;
  assign o_rvalid = rvalid;
  assign o_write_end_interrupt = write_end;
  assign o_write_busy_flag = write_busy_flag;
endmodule : nvw_top
`default_nettype wire

/* sim/nvw_cpu_model.sv */
// CPU core model issuing data memory accesses to the block
`default_nettype none
module nvw_cpu_model
  import nvw_pkg::*;
(
  // Clock
  input wire logic i_mclk,
  // Access towards the block
  output logic [NVW_ADDR_W-1:0] o_addr,
  output logic o_wr,
  output logic o_rd,
  output logic o_byte,
  output logic [7:0] o_wdata,
  input wire logic [7:0] i_rdata,
  input wire logic i_rvalid
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_addr = 12'h000;
    o_wr = 1'h0;
    o_rd = 1'h0;
    o_byte = 1'h1;
    o_wdata = 8'h00;
  end
  // Released lines are inverted so stale values never look valid
  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    input logic b);
    @(negedge i_mclk);
    o_addr = a;
    o_wdata = d;
    o_byte = b;
    o_wr = 1'h1;
    @(negedge i_mclk);
    o_wr = 1'h0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(negedge i_mclk);
    o_addr = a;
    o_byte = 1'h1;
    o_rd = 1'h1;
    @(negedge i_mclk);
    o_rd = 1'h0;
    o_addr = ~a;
    d = i_rdata;
  endtask : rd
endmodule : nvw_cpu_model
`default_nettype wire

/* sim/nvw_top_asserts.sv */
// Port checker for the write control block
`default_nettype none
module nvw_top_asserts
  import nvw_pkg::*;
#(
  parameter int unsigned P_LONG_WRITE_CYCLES = NVW_LONG_WRITE_CYCLES
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // Access, modes and status
  input wire logic [NVW_ADDR_W-1:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_byte,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic i_stop_mode,
  input wire logic i_halt_mode,
  input wire logic o_write_end_interrupt,
  input wire logic o_write_busy_flag
);
  // Shadow of read enable, select and write enable
  logic [4:0] ctl;
  logic [17:0] cnt;
  logic [17:0] exp_n;
  logic ctl_wr;
  logic arr;
  logic go;
  assign ctl_wr = i_wr && i_byte && i_addr == NVW_CTRL_ADDR;
  assign arr = i_addr[11:4] == 8'h40;
  assign go = i_wr && i_byte && arr && ctl[0] && !ctl[4]
    && !o_write_busy_flag && !i_stop_mode;
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctl <= 5'h00;
      cnt <= 18'h00000;
      exp_n <= 18'h00000;
    end else begin
      if (ctl_wr) begin
        ctl <= i_wdata[7:3];
      end
      if (go) begin
        exp_n <= 18'(P_LONG_WRITE_CYCLES >> ctl[3:1]) + 18'h00001;
      end
      cnt <= o_write_busy_flag ? cnt + 18'h00001 : 18'h00000;
    end
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  chk_busy_start: assert property (go |=> o_write_busy_flag)
    else $error("busy did not rise on an accepted write");
  chk_write_time: assert property (
    o_write_end_interrupt |-> cnt == exp_n)
    else $error("write length differs from the selected time");
  chk_end_fall: assert property (
    o_write_end_interrupt |-> $fell(o_write_busy_flag))
    else $error("write end without busy falling");
  chk_irq_pulse: assert property (
    o_write_end_interrupt |=> !o_write_end_interrupt)
    else $error("write end request longer than one cycle");
  chk_we_abort: assert property (
    o_write_busy_flag && ctl_wr && !i_wdata[3]
    |=> !o_write_busy_flag && !o_write_end_interrupt)
    else $error("clearing write enable did not abort");
  chk_stop_abort: assert property (
    o_write_busy_flag && i_stop_mode |-> ##[1:2] !o_write_busy_flag)
    else $error("stop mode did not halt the write");
  chk_rvalid_one: assert property (i_rd && !i_halt_mode |=> o_rvalid)
    else $error("read answer missing");
  chk_halt_quiet: assert property (
    i_rd && i_halt_mode |=> !o_rvalid)
    else $error("read answered while halted");
  chk_ctrl_read: assert property (
    i_rd && !i_halt_mode && i_addr == NVW_CTRL_ADDR
    |=> o_rdata == {$past(ctl), $past(o_write_busy_flag), 2'h0})
    else $error("control register read value wrong");
  chk_read_gate: assert property (
    i_rd && !i_halt_mode && arr && !(ctl[4] && !ctl[0]
    && !o_write_busy_flag) |=> o_rdata == 8'h00)
    else $error("array read outside read mode returned data");
  cov_write_end: cover property (o_write_end_interrupt);
  cov_we_abort: cover property (o_write_busy_flag && ctl_wr && !i_wdata[3]);
  cov_stop: cover property (o_write_busy_flag && i_stop_mode);
endmodule : nvw_top_asserts
bind nvw_top nvw_top_asserts #(
  .P_LONG_WRITE_CYCLES(P_LONG_WRITE_CYCLES)
) u_chk (
  .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wr(i_wr),
  .i_rd(i_rd), .i_byte(i_byte), .i_wdata(i_wdata), .o_rdata(o_rdata),
  .o_rvalid(o_rvalid), .i_stop_mode(i_stop_mode),
  .i_halt_mode(i_halt_mode),
  .o_write_end_interrupt(o_write_end_interrupt),
  .o_write_busy_flag(o_write_busy_flag)
);
`default_nettype wire

/* sim/testbench.sv */
// Self-checking bench for the write control block
`default_nettype none
module testbench
  import nvw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned LW = 576;
  localparam logic [11:0] CA = NVW_CTRL_ADDR;
  logic i_mclk = 1'h0;
  logic i_rst_b = 1'h0;
  logic stop = 1'h0;
  logic halt = 1'h0;
  logic [11:0] addr;
  logic wr;
  logic rd;
  logic byt;
  logic rvalid;
  logic irq;
  logic busy;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] got;
  int err_total = 0;
  int checked = 0;
  int n;
  always #50 i_mclk = ~i_mclk;
  nvw_cpu_model u_cpu (.i_mclk(i_mclk), .o_addr(addr), .o_wr(wr),
    .o_rd(rd), .o_byte(byt), .o_wdata(wdata), .i_rdata(rdata),
    .i_rvalid(rvalid));
  nvw_top #(.P_LONG_WRITE_CYCLES(LW)) u_dut (.i_mclk(i_mclk),
    .i_rst_b(i_rst_b), .i_addr(addr), .i_wr(wr), .i_rd(rd),
    .i_byte(byt), .i_wdata(wdata), .o_rdata(rdata), .o_rvalid(rvalid),
    .i_stop_mode(stop), .i_halt_mode(halt),
    .o_write_end_interrupt(irq), .o_write_busy_flag(busy));
  task automatic report_and_stop;
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk_byte(input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk_byte
  task automatic chk_count(input int e, input int g);
    checked++;
    if (g != e) begin
      err_total++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk_count
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
    u_cpu.rd(a, got);
    chk_byte(e, got);
    chk_byte(8'h01, {7'h00, rvalid});
  endtask : rd_chk
  // Counts falling edges until the write end request shows
  task automatic wait_end(input int n0);
    n = n0;
    while (irq !== 1'h1 && n < 1000) begin
      @(negedge i_mclk);
      n++;
    end
    if (n >= 1000) begin
      err_total++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, 1'h1, irq);
    end
  endtask : wait_end
  initial begin
    repeat (8) @(negedge i_mclk);
    i_rst_b = 1'h1;
    rd_chk(CA, 8'h00);
    u_cpu.wr(CA, 8'h5f, 1'h1);
    rd_chk(CA, 8'h58);
    u_cpu.wr(CA, 8'hff, 1'h0);
    rd_chk(CA, 8'h58);
    i_rst_b = 1'h0;
    @(negedge i_mclk);
    i_rst_b = 1'h1;
    rd_chk(CA, 8'h00);
    $display("register test done");
    for (int s = 0; s < 6; s++) begin
      u_cpu.wr(CA, {1'h0, 3'(s), 4'h8}, 1'h1);
      u_cpu.wr(12'h400 + 12'(s), 8'ha0 + 8'(s), 1'h1);
      chk_byte(8'h01, {7'h00, busy});
      u_cpu.wr(12'h400 + 12'(s), 8'h3c, 1'h1);
      wait_end(2);
      chk_count(int'(LW >> s) + 1, n);
      chk_byte(8'h00, {7'h00, busy});
      u_cpu.wr(CA, 8'h00, 1'h1);
    end
    $display("write timing test done");
    u_cpu.wr(CA, 8'h80, 1'h1);
    repeat (150) @(negedge i_mclk);
    for (int s = 0; s < 6; s++) begin
      rd_chk(12'h400 + 12'(s), 8'ha0 + 8'(s));
    end
    rd_chk(12'h7f0, 8'h00);
    u_cpu.wr(CA, 8'h88, 1'h1);
    rd_chk(12'h400, 8'h00);
    u_cpu.wr(12'h400, 8'h11, 1'h1);
    chk_byte(8'h00, {7'h00, busy});
    $display("read mode test done");
    u_cpu.wr(CA, 8'h58, 1'h1);
    u_cpu.wr(12'h400, 8'h99, 1'h0);
    chk_byte(8'h00, {7'h00, busy});
    u_cpu.wr(12'h400, 8'h77, 1'h1);
    repeat (5) @(negedge i_mclk);
    u_cpu.wr(CA, 8'h50, 1'h1);
    chk_byte(8'h00, {7'h00, busy | irq});
    u_cpu.wr(CA, 8'h80, 1'h1);
    repeat (150) @(negedge i_mclk);
    rd_chk(12'h400, 8'h00);
    $display("abort test done");
    u_cpu.wr(CA, 8'h58, 1'h1);
    u_cpu.wr(12'h401, 8'h66, 1'h1);
    stop = 1'h1;
    repeat (3) @(negedge i_mclk);
    chk_byte(8'h00, {7'h00, busy});
    stop = 1'h0;
    $display("stop test done");
    halt = 1'h1;
    u_cpu.wr(12'h402, 8'h55, 1'h1);
    wait_end(0);
    chk_count(int'(LW >> 5) + 1, n);
    u_cpu.rd(CA, got);
    chk_byte(8'h00, {7'h00, rvalid});
    halt = 1'h0;
    u_cpu.wr(CA, 8'h00, 1'h1);
    $display("halt test done");
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
